//--- pp_write_map.vh
// offsets, fields, reset values and timing counts of the parallel port write block
// assumes inclusion by bare name from the design files
`ifndef PP_WRITE_MAP_VH
`define PP_WRITE_MAP_VH

// register offsets on the plain register port
`define PP_OFS_CTRL 4'h0
`define PP_OFS_ADDR 4'h1
`define PP_OFS_DATA 4'h2
`define PP_OFS_STAT 4'h3

// port_control_reg fields
`define PP_CTL_EN_BIT 0
`define PP_CTL_DUR_LSB 1
`define PP_CTL_DUR_MSB 5
`define PP_CTL_HOLD_BIT 6
`define PP_CTL_FLASH_BIT 7
`define PP_CTL_ALE_LOW_BIT 8
`define PP_CTL_WIDE_BIT 9
`define PP_CTL_PACK_LSB 10
`define PP_CTL_PACK_MSB 11
`define PP_CTL_RESET 12'h000

// status fields
`define PP_STAT_BUSY_BIT 0
`define PP_STAT_DUR_ERR_BIT 1

// timing, in core and peripheral clock periods
`define PP_CORE_CLK_NS 50
`define PP_PCLK_RATIO 2
`define PP_PCLK_NS (`PP_CORE_CLK_NS * `PP_PCLK_RATIO)
`define PP_ALE_PCLKS 5'h02
`define PP_ADDR_HOLD_PCLKS 5'h01
`define PP_ALE_TO_WR_PCLKS 5'h02
`define PP_FLASH_PCLKS 5'h07
`define PP_FLASH_MIN_DUR 5'h09
`define PP_GAP_PCLKS 5'h01
`define PP_BYTE_BEATS 2'h3

`endif

//--- pclk_enable.v
// peripheral clock enable: one pulse every RATIO core clocks
// assumes a free running core clock; ce_i low freezes the divider
`timescale 1ns/100ps
module pclk_enable #(
    parameter RATIO = 2
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire ce_i,
    output wire tick_o
);
    reg [3:0] div_q;
    wire [3:0] div_d;

    assign div_d = (div_q == RATIO[3:0] - 4'h1) ? 4'h0 : div_q + 4'h1;
    assign tick_o = (div_q == RATIO[3:0] - 4'h1);

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= 4'h0;
        end else if (ce_i) begin
            div_q <= div_d;
        end
    end
endmodule

//--- pp_write.v
// write side of a multiplexed address/data parallel port
// assumes synchronous register strobes and a 20 MHz core clock on ref_clk_i
`timescale 1ns/100ps
`include "pp_write_map.vh"

// How it works
// R01 - 8-bit mode sends four write strobes after every latched address.
// R02 - address latch strobe is active high after reset; control bit selects active low.
// R03 - 16-bit: nonzero packing gives one strobe per latch, zero gives two.
// R04 - strobe low time is duration field minus flash recovery, in peripheral clocks.
// R05 - flash mode adds seven clocks recovery; software must program duration of at least nine.
// R06 - hold cycle keeps data and upper address one extra peripheral clock.
// R07 - all phases are timed from a peripheral clock of two core clocks.
// R08 - latch strobe lasts two peripheral clocks, then two more before first strobe.
// R09 - full address is on the shared lines through the latch strobe.
// R10 - address stays one peripheral clock after the latch strobe releases.
// R11 - strobe stays high recovery plus hold plus one clock between strobes.
// R12 - 8-bit mode drives upper address on high lines, data on low lines.
// R13 - 16-bit mode drives data on all sixteen lines around the strobe.
// R14 - next latch phase waits for last strobe release and hold cycle.
// R15 - sequencer is a state machine loading a counter from the duration field.
// R16 - external latch captures on latch strobe release, memory on strobe rising edge.
module pp_write #(
    parameter PCLK_RATIO = `PP_PCLK_RATIO
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg ale_o,
    output reg wr_n_o,
    output reg [15:0] muxed_addr_data_o,
    output reg muxed_lo_oe_o,
    output reg muxed_hi_oe_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ALE = 3'h1;
    localparam ST_AHOLD = 3'h2;
    localparam ST_GAP = 3'h3;
    localparam ST_STROBE = 3'h4;
    localparam ST_HOLD = 3'h5;
    localparam ST_RECOV = 3'h6;

    reg [11:0] port_control_reg;
    reg [15:0] addr_q;
    reg [31:0] data_q;
    reg dur_err_q;
    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg [1:0] beat_q;
    reg [1:0] last_beat_q;
    reg start_q;
    wire tick;

    wire ctl_en = port_control_reg[`PP_CTL_EN_BIT];
    wire [4:0] strobe_duration_field = port_control_reg[`PP_CTL_DUR_MSB:`PP_CTL_DUR_LSB];
    wire hold_cfg = port_control_reg[`PP_CTL_HOLD_BIT];
    wire flash_cfg = port_control_reg[`PP_CTL_FLASH_BIT];
    wire ale_low = port_control_reg[`PP_CTL_ALE_LOW_BIT];
    wire wide_cfg = port_control_reg[`PP_CTL_WIDE_BIT];
    wire [1:0] packing_select = port_control_reg[`PP_CTL_PACK_MSB:`PP_CTL_PACK_LSB];
    wire busy = (state_q != ST_IDLE) || start_q;
    wire [4:0] recov_pclks = flash_cfg ? `PP_FLASH_PCLKS : 5'h00;
    wire [4:0] strobe_pclks;
    wire [1:0] beats_last;

    // strobe low time D - F, never below one peripheral clock
    assign strobe_pclks = (strobe_duration_field > recov_pclks + 5'h01) ?
        strobe_duration_field - recov_pclks : 5'h01; // R04
    assign beats_last = !wide_cfg ? `PP_BYTE_BEATS : // R01
        ((packing_select != 2'h0) ? 2'h0 : 2'h1); // R03

    // data of one beat: bytes or halfwords, lowest first
    function [15:0] beat_data;
        input [31:0] word;
        input [1:0] beat;
        input wide;
        input [7:0] upper_addr;
        begin
            if (wide) begin
                beat_data = beat[0] ? word[31:16] : word[15:0]; // R13
            end else begin
                case (beat)
                    2'h0: beat_data = {upper_addr, word[7:0]}; // R12
                    2'h1: beat_data = {upper_addr, word[15:8]};
                    2'h2: beat_data = {upper_addr, word[23:16]};
                    default: beat_data = {upper_addr, word[31:24]};
                endcase
            end
        end
    endfunction

    pclk_enable #(
        .RATIO(PCLK_RATIO)
    ) u_pclk (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .tick_o(tick) // R07
    );

    // register port
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_control_reg <= `PP_CTL_RESET; // R02
            addr_q <= 16'h0000;
            data_q <= 32'h00000000;
            dur_err_q <= 1'b0;
            start_q <= 1'b0;
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            rdata_o <= 32'h00000000;
            if (start_q && tick && state_q == ST_IDLE) begin
                start_q <= 1'b0;
            end
            if (wr_i && !busy) begin
                case (addr_i)
                    `PP_OFS_CTRL: begin
                        port_control_reg <= wdata_i[11:0];
                    end
                    `PP_OFS_ADDR: begin
                        addr_q <= wdata_i[15:0];
                    end
                    `PP_OFS_DATA: begin
                        data_q <= wdata_i;
                        start_q <= ctl_en;
                    end
                    default: begin
                    end
                endcase
            end
            // error set on start wins over a clear in the same cycle
            if (wr_i && !busy && addr_i == `PP_OFS_DATA && ctl_en && flash_cfg &&
                strobe_duration_field < `PP_FLASH_MIN_DUR) begin
                dur_err_q <= 1'b1; // R05
            end else if (wr_i && addr_i == `PP_OFS_STAT &&
                         wdata_i[`PP_STAT_DUR_ERR_BIT]) begin
                dur_err_q <= 1'b0;
            end
            if (rd_i) begin
                case (addr_i)
                    `PP_OFS_CTRL: rdata_o <= {20'h00000, port_control_reg};
                    `PP_OFS_ADDR: rdata_o <= {16'h0000, addr_q};
                    `PP_OFS_DATA: rdata_o <= data_q;
                    `PP_OFS_STAT: rdata_o <= {30'h00000000, dur_err_q, busy};
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // write sequencer, advances once per peripheral clock
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            beat_q <= 2'h0;
            last_beat_q <= 2'h0;
            ale_o <= 1'b0;
            wr_n_o <= 1'b1;
            muxed_addr_data_o <= 16'h0000;
            muxed_lo_oe_o <= 1'b0;
            muxed_hi_oe_o <= 1'b0;
        end else if (ce_i && tick) begin
            case (state_q)
                ST_IDLE: begin
                    ale_o <= ale_low; // R02
                    wr_n_o <= 1'b1;
                    muxed_lo_oe_o <= 1'b0;
                    muxed_hi_oe_o <= 1'b0;
                    if (start_q) begin
                        ale_o <= !ale_low;
                        muxed_addr_data_o <= addr_q; // R09
                        muxed_lo_oe_o <= 1'b1;
                        muxed_hi_oe_o <= 1'b1;
                        last_beat_q <= beats_last;
                        beat_q <= 2'h0;
                        cnt_q <= `PP_ALE_PCLKS - 5'h01; // R08
                        state_q <= ST_ALE;
                    end
                end
                ST_ALE: begin
                    if (cnt_q == 5'h00) begin
                        ale_o <= ale_low;
                        cnt_q <= `PP_ADDR_HOLD_PCLKS - 5'h01;
                        state_q <= ST_AHOLD; // R10
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_AHOLD: begin
                    if (cnt_q == 5'h00) begin
                        // data and upper address ahead of the strobe
                        muxed_addr_data_o <= beat_data(data_q, 2'h0, wide_cfg, addr_q[15:8]);
                        cnt_q <= `PP_ALE_TO_WR_PCLKS - `PP_ADDR_HOLD_PCLKS - 5'h01;
                        state_q <= ST_GAP; // R08
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_GAP: begin
                    if (cnt_q == 5'h00) begin
                        wr_n_o <= 1'b0;
                        cnt_q <= strobe_pclks - 5'h01; // R15
                        state_q <= ST_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_STROBE: begin
                    if (cnt_q == 5'h00) begin
                        wr_n_o <= 1'b1;
                        if (hold_cfg) begin
                            cnt_q <= 5'h00;
                            state_q <= ST_HOLD; // R06
                        end else if (beat_q == last_beat_q) begin
                            muxed_lo_oe_o <= 1'b0;
                            muxed_hi_oe_o <= 1'b0;
                            state_q <= ST_IDLE; // R14
                        end else begin
                            // no recovery: next beat goes out as the strobe rises
                            if (recov_pclks == 5'h00) begin
                                muxed_addr_data_o <= beat_data(data_q, beat_q + 2'h1,
                                                               wide_cfg, addr_q[15:8]);
                            end
                            cnt_q <= recov_pclks + `PP_GAP_PCLKS - 5'h01; // R11
                            state_q <= ST_RECOV;
                        end
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_HOLD: begin
                    if (beat_q == last_beat_q) begin
                        muxed_lo_oe_o <= 1'b0;
                        muxed_hi_oe_o <= 1'b0;
                        state_q <= ST_IDLE; // R14
                    end else begin
                        // hold done: next beat may go out now
                        if (recov_pclks == 5'h00) begin
                            muxed_addr_data_o <= beat_data(data_q, beat_q + 2'h1, wide_cfg,
                                                           addr_q[15:8]); // R06
                        end
                        cnt_q <= recov_pclks + `PP_GAP_PCLKS - 5'h01; // R11
                        state_q <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (cnt_q == `PP_GAP_PCLKS) begin
                        // next beat set up one clock ahead of its strobe
                        muxed_addr_data_o <= beat_data(data_q, beat_q + 2'h1, wide_cfg,
                                                       addr_q[15:8]); // R12 R13
                    end
                    if (cnt_q == 5'h00) begin
                        beat_q <= beat_q + 2'h1;
                        wr_n_o <= 1'b0;
                        cnt_q <= strobe_pclks - 5'h01; // R04
                        state_q <= ST_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- pp_write_sva.sv
// pin timing assertions for the parallel port write block
// assumes ce_i stays high and ctrl is written only while the port is idle
`timescale 1ns/100ps
`include "pp_write_map.vh"
module pp_write_sva #(
    parameter PCLK_RATIO = 2
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire ale_o,
    input wire wr_n_o,
    input wire [15:0] muxed_addr_data_o,
    input wire muxed_lo_oe_o,
    input wire muxed_hi_oe_o
);
    reg idle_q, hold_q, flash_q, grp_q;
    reg [4:0] dur_q;
    reg [7:0] lowc_q, highc_q;
    wire oe = muxed_lo_oe_o & muxed_hi_oe_o;
    wire act = oe & (ale_o ^ idle_q);
    wire [4:0] dn = dur_q | {4'h0, dur_q == 5'h00};
    wire [4:0] df = !flash_q ? dn : (dur_q > 5'h07) ? dur_q - 5'h07 : 5'h01;
    wire [7:0] r = PCLK_RATIO[7:0];
    wire [7:0] low_exp = {3'h0, df} * r;
    wire [7:0] gap_exp = ({5'h0, {3{flash_q}}} + {7'h0, hold_q} + 8'h01) * r;
    wire [7:0] rest_exp = ({7'h0, hold_q} + 8'h01) * r;
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {idle_q, hold_q, flash_q, grp_q, dur_q} <= 9'h000;
            lowc_q <= 8'h00;
            highc_q <= 8'hff;
        end else begin
            // idle latch level learnt while the lines are released
            if (!oe) idle_q <= ale_o;
            if (wr_i && addr_i == `PP_OFS_CTRL) {flash_q, hold_q, dur_q} <= wdata_i[7:1];
            lowc_q <= wr_n_o ? 8'h00 : lowc_q + 8'h01;
            highc_q <= !wr_n_o ? 8'h00 : highc_q + {7'h0, highc_q != 8'hff};
            grp_q <= !act & (grp_q | !wr_n_o);
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_ale_pulse; act [*4] ##1 !act; endsequence
    sequence s_wr_wait; wr_n_o [*4] ##1 !wr_n_o; endsequence
    sequence s_held; ($stable(muxed_addr_data_o) && oe) [*2]; endsequence
    a_ale_width: assert property ($rose(act) |-> s_ale_pulse)
        else $error("latch strobe width wrong");
    a_addr_stable: assert property ($rose(act) |-> ##1 s_held ##1 s_held ##1 ($stable(muxed_addr_data_o) && oe))
        else $error("address moved near latch strobe");
    a_ale_to_wr: assert property ($fell(act) |-> s_wr_wait)
        else $error("latch to strobe gap wrong");
    a_strobe_low: assert property ($rose(wr_n_o) |-> lowc_q == low_exp)
        else $error("strobe low time wrong");
    a_gap_high: assert property ($fell(wr_n_o) && grp_q |-> highc_q == gap_exp)
        else $error("strobe recovery wrong");
    a_hold_data: assert property ($rose(wr_n_o) && hold_q |-> s_held)
        else $error("data not held");
    a_data_stable: assert property (!wr_n_o |-> $stable(muxed_addr_data_o) && oe && !act)
        else $error("lines moved under strobe");
    a_ale_rest: assert property ($rose(act) |-> highc_q >= rest_exp)
        else $error("latch phase too soon");
endmodule
bind pp_write pp_write_sva #(.PCLK_RATIO(PCLK_RATIO)) sva_i (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .ale_o(ale_o),
    .wr_n_o(wr_n_o), .muxed_addr_data_o(muxed_addr_data_o),
    .muxed_lo_oe_o(muxed_lo_oe_o), .muxed_hi_oe_o(muxed_hi_oe_o));

//--- ext_mem_model.sv
// external memory behind the port: address latch and write capture
// assumes registered port outputs, so it samples on the falling clock
`timescale 1ns/100ps
module ext_mem_model (
    input wire ref_clk_i,
    input wire ale_i,
    input wire ale_low_i,
    input wire wr_n_i,
    input wire oe_i,
    input wire [15:0] lines_i,
    output reg [15:0] lat_addr_o,
    output reg [63:0] words_o,
    output reg [7:0] beats_o
);
    reg act_q = 1'b0, wr_n_q = 1'b1;
    reg [15:0] lines_q = 16'h0;
    wire act = ale_i ^ ale_low_i;
    always @(negedge ref_clk_i) begin
        act_q <= act;
        wr_n_q <= wr_n_i;
        // released lines show the inverse of the last value
        lines_q <= oe_i ? lines_i : ~lines_q;
        if (act && !act_q) begin
            words_o <= 64'h0;
            beats_o <= 8'h00;
        end
        if (!act && act_q) lat_addr_o <= lines_q;
        if (wr_n_i && !wr_n_q) begin
            words_o <= {words_o[47:0], lines_q};
            beats_o <= beats_o + 8'h01;
        end
    end
endmodule

//--- pp_write_bench.sv
// self-checking bench for the parallel port write block
// assumes the memory model and the bound checker are compiled with it
`timescale 1ns/100ps
`include "pp_write_map.vh"
module pp_write_bench;
    reg ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ale_low = 1'b0;
    reg [3:0] addr_i = 4'h0;
    reg [31:0] wdata_i = 32'h0, s;
    wire [31:0] rdata_o;
    wire ale_o, wr_n_o, lo_oe, hi_oe;
    wire [15:0] lines, lat_addr;
    wire [63:0] words;
    wire [7:0] beats;
    integer miscompares = 0, n_compared = 0, i, k;
    // ctrl, strobe count, address, data
    localparam [0:6][63:0] rows = {64'h007_4_12a5_a1b2c3d4, 64'h647_1_5a3c_1357beef,
        64'h205_2_ff00_cafe0123, 64'ha93_1_0001_89abcdef, 64'h1d5_4_8001_01020304,
        64'he03_1_7ffe_fedcba98, 64'h03f_4_00ff_55aa55aa};
    pp_write #(.PCLK_RATIO(2)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ale_o(ale_o), .wr_n_o(wr_n_o), .muxed_addr_data_o(lines), .muxed_lo_oe_o(lo_oe),
        .muxed_hi_oe_o(hi_oe));
    ext_mem_model mem (.ref_clk_i(ref_clk_i), .ale_i(ale_o), .ale_low_i(ale_low),
        .wr_n_i(wr_n_o), .oe_i(lo_oe & hi_oe), .lines_i(lines), .lat_addr_o(lat_addr),
        .words_o(words), .beats_o(beats));
    task chk(input [63:0] seen, input [63:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd_reg(input [3:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 s = rdata_o;
    endtask
    task idle;
        s = 32'h1;
        for (k = 0; k < 300 && s[0] === 1'b1; k = k + 1) rd_reg(`PP_OFS_STAT);
        chk({63'h0, s[0]}, 64'h0);
    endtask
    function [63:0] exp_w(input [11:0] c, input [15:0] a, input [31:0] d);
        if (!c[`PP_CTL_WIDE_BIT])
            exp_w = {a[15:8], d[7:0], a[15:8], d[15:8], a[15:8], d[23:16], a[15:8], d[31:24]};
        else if (c[11:10] == 2'h0)
            exp_w = {32'h0, d[15:0], d[31:16]};
        else
            exp_w = {48'h0, d[15:0]};
    endfunction
    task xfer(input [11:0] c, input [15:0] a, input [31:0] d, input [3:0] nb);
        wr_reg(`PP_OFS_CTRL, {20'h0, c});
        ale_low <= c[`PP_CTL_ALE_LOW_BIT];
        wr_reg(`PP_OFS_ADDR, {16'h0, a});
        wr_reg(`PP_OFS_DATA, d);
        idle;
        chk({48'h0, lat_addr}, {48'h0, a});
        chk(words, exp_w(c, a, d));
        chk({56'h0, beats}, {60'h0, nb});
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial forever #25 ref_clk_i = ~ref_clk_i;
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares = miscompares + 1;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 chk({60'h0, ale_o, wr_n_o, lo_oe, hi_oe}, 64'h4);
        rd_reg(4'h5);
        chk({32'h0, s}, 64'h0);
        $display("reset test done");
        for (i = 0; i < 7; i = i + 1) begin
            xfer(rows[i][63:52], rows[i][47:32], rows[i][31:0], rows[i][51:48]);
            $display("row %0d done", i);
        end
        xfer(12'h691, 16'h4321, 32'h00005678, 4'h1);
        rd_reg(`PP_OFS_STAT);
        chk({63'h0, s[1]}, 64'h1);
        wr_reg(`PP_OFS_STAT, 32'h2);
        rd_reg(`PP_OFS_STAT);
        chk({63'h0, s[1]}, 64'h0);
        $display("short flash duration test done");
        wr_reg(`PP_OFS_CTRL, 32'h607);
        wr_reg(`PP_OFS_DATA, 32'h0000aaaa);
        wr_reg(`PP_OFS_DATA, 32'h00005555);
        idle;
        chk(words, 64'haaaa);
        chk({56'h0, beats}, 64'h1);
        $display("busy refusal test done");
        complete_run;
    end
endmodule
